// ### src/lds_defines.svh
// register offsets, reset values and timing constants of the LED driver control slice
// assumes inclusion by bare name from the top module and the testbench
`ifndef LDS_DEFINES_SVH
`define LDS_DEFINES_SVH

// ==========================================================================
// register byte offsets
`define LDS_OFS_CTRL 8'h00
`define LDS_OFS_FREQ 8'h04
`define LDS_OFS_SLOPE 8'h08
`define LDS_OFS_STATUS_LIVE_FIRST 8'h0C
`define LDS_OFS_RISE1 8'h10
`define LDS_OFS_FALL1 8'h14
`define LDS_OFS_STAT2 8'h18
`define LDS_OFS_RISE2 8'h1C
`define LDS_OFS_FALL2 8'h20
`define LDS_OFS_RMASK 8'h24
`define LDS_OFS_FMASK 8'h28
`define LDS_OFS_RES0 8'h40
`define LDS_OFS_RES_LAST 8'h60

// ==========================================================================
// field positions and reset values
`define LDS_CTRL_MEAS_BIT 0
`define LDS_FREQ_RESET 6'h04
`define LDS_FREQ_LAST 6'h1A
`define LDS_FREQ_LINEAR_LAST 6'h0A
`define LDS_DIV_BASE 8'h08
`define LDS_DIV_MAX 8'hB4
`define LDS_SLOPE_LOW_RESET 2'h0
`define LDS_SLOPE_HIGH_RESET 2'h0
`define LDS_RES_SHIFT 6
`define LDS_DIE_CH 4'h9

// ==========================================================================
// timing
`define LDS_CLK_HZ 20000000
`define LDS_MEAS_PERIOD_MS 100

`endif

// ### src/lds_pkg.sv
// types shared by the LED driver control slice
// uses no macros from lds_defines.svh
package lds_pkg;

  // converter sweep states, gray along idle -> convert -> store
  typedef enum logic [1:0] {
    LDS_IDLE = 2'b00,
    LDS_CONV = 2'b01,
    LDS_STORE = 2'b11
  } lds_meas_e;

  // request to the shared converter
  typedef struct packed {
    logic start;
    logic [3:0] channel;
  } lds_adc_req_s;

  // slope settings: low-duty code in [1:0], high-duty code in [3:2]
  typedef struct packed {
    logic [1:0] high_duty;
    logic [1:0] low_duty;
  } lds_slope_s;

endpackage

// ### src/lds_top.sv
// control slice of a connected LED driver: switching clock divider, slope select,
// converter sequencer with result registers, status latches, Avalon-MM slave
// assumes status conditions and converter handshake arrive asynchronously on pins
//
// The address map and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "lds_defines.svh"

// Operation
// - switching clock divided from main clock by code
// - divisor 8+2*code, then fixed table to 180
// - reset code 4 gives divisor 16
// - low slope below half duty, else high
// - low slope codes give 0.1 to 0.4 V/us
// - high slope codes give 0.3 to 0.9 V/us
// - reset slopes are 0.1 and 0.3 V/us
// - one converter shared across ten quantities
// - no sampling while measurement enable is clear
// - every quantity refreshed once per 100 ms
// - results in 16-bit registers, scaled to 2^16
// - ten live bits over two 8-bit registers
// - heat warning while die temperature exceeds limit
// - live bits follow condition without latching
// - rise latch sets on live bit activation
// - reading rise latch clears it
// - live and rise registers at adjacent addresses
// - fall latch sets on deactivation, clears on read
// - interrupt when any masked latch bit set
module lds_top #(
  parameter int MEAS_PERIOD_CYC =
    int'((64'(`LDS_MEAS_PERIOD_MS) * 64'(`LDS_CLK_HZ)) / 64'd1000), // 100 ms in clocks
  parameter logic [15:0] DIE_HEAT_LIMIT = 16'hC000, // die heat threshold, result scale
  parameter int NUM_STATUS = 10 // live status bits
) (
  input wire logic clk, // 20 MHz main clock
  input wire logic rstn, // async reset, active low
  input wire logic [7:0] address, // avalon byte address
  input wire logic read, // avalon read
  input wire logic write, // avalon write
  input wire logic [31:0] writedata, // avalon write data
  input wire logic [3:0] byteenable, // avalon byte enables
  output logic [31:0] readdata, // avalon read data
  output logic waitrequest, // avalon wait
  input wire logic [NUM_STATUS-1:1] status_cond, // async fault/warning conditions
  input wire logic duty_above_half, // async duty-cycle comparator
  output logic led_switching_clock, // divided switching clock
  output logic [9:0] slope_mv_per_us, // active compensation slope, mV/us
  output logic [3:0] adc_channel, // converter mux select
  output logic adc_start, // converter start pulse
  input wire logic adc_done, // async converter done level
  input wire logic [9:0] adc_data, // converter result, stable while done
  output logic interrupt_out_n_o, // open-drain pin drive value
  output logic interrupt_out_n_oe // open-drain pin pull-low enable
);

  // ==========================================================================
  // lookup functions
  function automatic logic [7:0] div_of(input logic [5:0] code);
    logic [7:0] d;
    d = `LDS_DIV_MAX;
    if (code <= `LDS_FREQ_LINEAR_LAST) begin
      d = `LDS_DIV_BASE + {1'b0, code, 1'b0};
    end else begin
      case (code)
        6'h0B: d = 8'h20;
        6'h0C: d = 8'h22;
        6'h0D: d = 8'h26;
        6'h0E: d = 8'h2A;
        6'h0F: d = 8'h2E;
        6'h10: d = 8'h34;
        6'h11: d = 8'h38;
        6'h12: d = 8'h40;
        6'h13: d = 8'h46;
        6'h14: d = 8'h4C;
        6'h15: d = 8'h54;
        6'h16: d = 8'h66;
        6'h17: d = 8'h70;
        6'h18: d = 8'h7C;
        6'h19: d = 8'h96;
        default: d = `LDS_DIV_MAX; // codes above the table hold the slowest rate
      endcase
    end
    return d;
  endfunction

  function automatic logic [9:0] slope_of(input logic high, input logic [1:0] code);
    logic [9:0] s;
    case ({high, code})
      3'h0: s = 10'h064;
      3'h1: s = 10'h0C8;
      3'h2: s = 10'h12C;
      3'h3: s = 10'h190;
      3'h4: s = 10'h12C;
      3'h5: s = 10'h190;
      3'h6: s = 10'h258;
      default: s = 10'h384;
    endcase
    return s;
  endfunction

  // ==========================================================================
  // input synchronisers
  logic [NUM_STATUS-1:1] cond_s1, cond_s2;
  logic duty_s1, duty_s2, done_s1, done_s2;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cond_s1 <= '0;
      cond_s2 <= '0;
      duty_s1 <= 1'b0;
      duty_s2 <= 1'b0;
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
    end else begin
      cond_s1 <= status_cond;
      cond_s2 <= cond_s1;
      duty_s1 <= duty_above_half;
      duty_s2 <= duty_s1;
      done_s1 <= adc_done;
      done_s2 <= done_s1;
    end
  end

  // ==========================================================================
  // bus slave: one wait state on every access
  logic ack;
  wire req = read | write;
  assign waitrequest = req & ~ack;
  wire wr_fire = write & ~waitrequest;
  wire rd_fire = read & ~waitrequest;
  wire wr_ctrl = wr_fire & (address == `LDS_OFS_CTRL) & byteenable[0];
  wire wr_freq = wr_fire & (address == `LDS_OFS_FREQ) & byteenable[0];
  wire wr_slope = wr_fire & (address == `LDS_OFS_SLOPE) & byteenable[0];
  wire wr_rmask = wr_fire & (address == `LDS_OFS_RMASK);
  wire wr_fmask = wr_fire & (address == `LDS_OFS_FMASK);
  wire rd_rise1 = rd_fire & (address == `LDS_OFS_RISE1);
  wire rd_rise2 = rd_fire & (address == `LDS_OFS_RISE2);
  wire rd_fall1 = rd_fire & (address == `LDS_OFS_FALL1);
  wire rd_fall2 = rd_fire & (address == `LDS_OFS_FALL2);

  logic metrology_enable;
  logic [5:0] switch_freq_divider_select;
  lds_pkg::lds_slope_s slope_comp_setting;
  logic [NUM_STATUS-1:0] rise_mask, fall_mask;
  logic [NUM_STATUS-1:0] status_live, status_live_q, status_rise_latch, status_fall_latch;
  logic [15:0] result [0:8];
  logic [15:0] die_temp;

  // masks keep only the bytes enabled; bit 8 and up sit in byte 1
  wire [NUM_STATUS-1:0] wmask = {{(NUM_STATUS-8){byteenable[1]}}, {8{byteenable[0]}}};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      metrology_enable <= 1'b0;
      switch_freq_divider_select <= `LDS_FREQ_RESET;
      slope_comp_setting <= {`LDS_SLOPE_HIGH_RESET, `LDS_SLOPE_LOW_RESET};
      rise_mask <= '0;
      fall_mask <= '0;
    end else begin
      if (wr_ctrl) metrology_enable <= writedata[`LDS_CTRL_MEAS_BIT];
      if (wr_freq) switch_freq_divider_select <= writedata[5:0];
      if (wr_slope) slope_comp_setting <= writedata[3:0];
      if (wr_rmask) rise_mask <= (rise_mask & ~wmask) | (writedata[NUM_STATUS-1:0] & wmask);
      if (wr_fmask) fall_mask <= (fall_mask & ~wmask) | (writedata[NUM_STATUS-1:0] & wmask);
    end
  end

  // live and rise registers adjacent for one burst
  wire [7:0] res_ofs = address - `LDS_OFS_RES0;
  wire res_hit = (address >= `LDS_OFS_RES0) && (address <= `LDS_OFS_RES_LAST) &&
                 (address[1:0] == 2'h0);
  wire [3:0] res_idx = res_ofs[5:2];
  logic [31:0] next_readdata;
  always_comb begin
    next_readdata = 32'h0;
    case (address)
      `LDS_OFS_CTRL: next_readdata[`LDS_CTRL_MEAS_BIT] = metrology_enable;
      `LDS_OFS_FREQ: next_readdata[5:0] = switch_freq_divider_select;
      `LDS_OFS_SLOPE: next_readdata[3:0] = slope_comp_setting;
      `LDS_OFS_STATUS_LIVE_FIRST: next_readdata[7:0] = status_live[7:0];
      `LDS_OFS_RISE1: next_readdata[7:0] = status_rise_latch[7:0];
      `LDS_OFS_FALL1: next_readdata[7:0] = status_fall_latch[7:0];
      `LDS_OFS_STAT2: next_readdata[1:0] = status_live[9:8];
      `LDS_OFS_RISE2: next_readdata[1:0] = status_rise_latch[9:8];
      `LDS_OFS_FALL2: next_readdata[1:0] = status_fall_latch[9:8];
      `LDS_OFS_RMASK: next_readdata[NUM_STATUS-1:0] = rise_mask;
      `LDS_OFS_FMASK: next_readdata[NUM_STATUS-1:0] = fall_mask;
      default: if (res_hit) next_readdata[15:0] = result[res_idx];
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack <= 1'b0;
      readdata <= 32'h0;
    end else begin
      ack <= req & ~ack;
      if (req & ~ack) readdata <= next_readdata;
    end
  end

  // ==========================================================================
  // switching clock divider
  logic [7:0] div_cnt;
  wire [7:0] divisor = div_of(switch_freq_divider_select);
  wire div_wrap = (div_cnt >= divisor - 8'h01);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_cnt <= 8'h00;
      led_switching_clock <= 1'b0;
    end else begin
      div_cnt <= div_wrap ? 8'h00 : div_cnt + 8'h01;
      led_switching_clock <= (div_wrap | (div_cnt < {1'b0, divisor[7:1]} - 8'h01));
    end
  end

  // ==========================================================================
  // slope compensation select; the host may write zero when margin is short
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      slope_mv_per_us <= 10'h000;
    end else begin
      slope_mv_per_us <= duty_s2 ? slope_of(1'b1, slope_comp_setting.high_duty)
                                 : slope_of(1'b0, slope_comp_setting.low_duty);
    end
  end

  // ==========================================================================
  // converter sequencer: one sweep of all channels per period
  lds_pkg::lds_meas_e state, next_state;
  lds_pkg::lds_adc_req_s adc_req, next_adc_req;
  logic [31:0] period_cnt;
  wire period_tick = (period_cnt == 32'(MEAS_PERIOD_CYC - 1));
  logic sweep_pending;
  wire last_ch = (adc_req.channel == `LDS_DIE_CH);

  always_comb begin
    next_state = state;
    next_adc_req = adc_req;
    next_adc_req.start = 1'b0;
    case (state)
      lds_pkg::LDS_IDLE: begin
        if (sweep_pending && metrology_enable) begin
          next_state = lds_pkg::LDS_CONV;
          next_adc_req.start = 1'b1;
        end
      end
      lds_pkg::LDS_CONV: begin
        if (done_s2) next_state = lds_pkg::LDS_STORE;
      end
      lds_pkg::LDS_STORE: begin
        // wait for done to drop so one conversion is stored once
        if (!done_s2) begin
          if (last_ch || !metrology_enable) begin
            next_state = lds_pkg::LDS_IDLE;
            next_adc_req.channel = 4'h0;
          end else begin
            next_state = lds_pkg::LDS_CONV;
            next_adc_req.channel = adc_req.channel + 4'h1;
            next_adc_req.start = 1'b1;
          end
        end
      end
      default: next_state = lds_pkg::LDS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= lds_pkg::LDS_IDLE;
      adc_req <= '0;
      period_cnt <= 32'h0;
      sweep_pending <= 1'b0;
    end else begin
      state <= next_state;
      adc_req <= next_adc_req;
      period_cnt <= (period_tick || !metrology_enable) ? 32'h0 : period_cnt + 32'h1;
      if (period_tick) sweep_pending <= 1'b1;
      else if (next_adc_req.start && state == lds_pkg::LDS_IDLE) sweep_pending <= 1'b0;
    end
  end
  assign adc_start = adc_req.start;
  assign adc_channel = adc_req.channel;

  // capture on the store entry; full scale maps to 2^16
  wire store_now = (state == lds_pkg::LDS_CONV) && done_s2;
  wire [15:0] scaled = {adc_data, {`LDS_RES_SHIFT{1'b0}}};
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      die_temp <= 16'h0;
    end else if (store_now && last_ch) begin
      die_temp <= scaled;
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < 9; gi++) begin : g_res
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) result[gi] <= 16'h0;
        else if (store_now && adc_req.channel == 4'(gi)) result[gi] <= scaled;
      end
    end
  endgenerate

  // ==========================================================================
  // live status and transition latches
  wire die_heat_warning = (die_temp > DIE_HEAT_LIMIT);
  wire [NUM_STATUS-1:0] rise_evt = status_live & ~status_live_q;
  wire [NUM_STATUS-1:0] fall_evt = ~status_live & status_live_q;
  wire [NUM_STATUS-1:0] rise_clr = {{(NUM_STATUS-8){rd_rise2}}, {8{rd_rise1}}};
  wire [NUM_STATUS-1:0] fall_clr = {{(NUM_STATUS-8){rd_fall2}}, {8{rd_fall1}}};
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_live <= '0;
      status_live_q <= '0;
      status_rise_latch <= '0;
      status_fall_latch <= '0;
      interrupt_out_n_oe <= 1'b0;
    end else begin
      status_live <= {cond_s2, die_heat_warning};
      status_live_q <= status_live;
      status_rise_latch <= (status_rise_latch & ~rise_clr) | rise_evt;
      status_fall_latch <= (status_fall_latch & ~fall_clr) | fall_evt;
      interrupt_out_n_oe <= |((status_rise_latch & rise_mask) |
                              (status_fall_latch & fall_mask));
    end
  end
  assign interrupt_out_n_o = 1'b0;

  // ==========================================================================
  // checks
  chk_div_legal: assert property (@(posedge clk) disable iff (!rstn)
    divisor >= `LDS_DIV_BASE && divisor <= `LDS_DIV_MAX && !divisor[0])
    else $error("switching divisor out of range");
  chk_clk_period: assert property (@(posedge clk) disable iff (!rstn)
    div_wrap |=> (div_cnt == 8'h00 && led_switching_clock))
    else $error("switching clock not high at period start");
  chk_rise_set: assert property (@(posedge clk) disable iff (!rstn)
    (rise_evt != '0) |=> ((status_rise_latch & $past(rise_evt)) == $past(rise_evt)))
    else $error("rise latch missed an activation");
  chk_rise_clear: assert property (@(posedge clk) disable iff (!rstn)
    (rd_rise1 && rise_evt[7:0] == 8'h00) |=> status_rise_latch[7:0] == 8'h00)
    else $error("rise latch not cleared by read");
  chk_set_wins: assert property (@(posedge clk) disable iff (!rstn)
    (rd_rise1 && rise_evt[7:0] != 8'h00) |=> ((status_rise_latch[7:0] & $past(rise_evt[7:0])) == $past(rise_evt[7:0])))
    else $error("activation lost to clearing read");
  chk_fall_set: assert property (@(posedge clk) disable iff (!rstn)
    (fall_evt != '0) |=> ((status_fall_latch & $past(fall_evt)) == $past(fall_evt)))
    else $error("fall latch missed a deactivation");
  chk_fall_clear: assert property (@(posedge clk) disable iff (!rstn)
    (rd_fall1 && fall_evt[7:0] == 8'h00) |=> status_fall_latch[7:0] == 8'h00)
    else $error("fall latch not cleared by read");
  chk_irq_level: assert property (@(posedge clk) disable iff (!rstn)
    ((status_rise_latch & rise_mask) != '0) |=> interrupt_out_n_oe)
    else $error("masked rise latch gave no interrupt");
  chk_meas_off: assert property (@(posedge clk) disable iff (!rstn)
    (!metrology_enable && state == lds_pkg::LDS_IDLE) |=> !adc_start)
    else $error("sampling started while disabled");
  chk_live_follow: assert property (@(posedge clk) disable iff (!rstn)
    ##1 status_live[NUM_STATUS-1:1] == $past(cond_s2))
    else $error("live status does not follow condition");
  chk_heat_warn: assert property (@(posedge clk) disable iff (!rstn)
    (die_temp > DIE_HEAT_LIMIT) |=> status_live[0])
    else $error("heat warning not raised");
  chk_slope_low: assert property (@(posedge clk) disable iff (!rstn)
    (!duty_s2 && slope_comp_setting.low_duty == 2'h0) |=> slope_mv_per_us == 10'h064)
    else $error("low duty slope wrong");
  chk_slope_high: assert property (@(posedge clk) disable iff (!rstn)
    (duty_s2 && slope_comp_setting.high_duty == 2'h0) |=> slope_mv_per_us == 10'h12C)
    else $error("high duty slope wrong");
  chk_bus_wait: assert property (@(posedge clk) disable iff (!rstn)
    (req && waitrequest) |=> !waitrequest)
    else $error("wait state longer than one cycle");

endmodule // lds_top
`default_nettype wire

// ### testbench/lds_conv_model.sv
// converter model on the far side of the metrology pins
// assumes the block pulses adc_start once per conversion and syncs adc_done itself
`timescale 1ns/1ns
`default_nettype none
module lds_conv_model (
  input wire logic clk, // main clock
  input wire logic rstn, // async reset, active low
  input wire logic adc_start, // conversion start pulse
  input wire logic [3:0] adc_channel, // mux select
  input wire logic hot, // die above heat limit
  input wire logic slow, // stretch conversion time
  output logic adc_done, // result valid level
  output logic [9:0] adc_data // result
);
  logic [3:0] ch;
  logic [3:0] wait_cnt;
  logic [2:0] hold_cnt;
  // ==========================================================================
  // conversion timing
  // data is inverted once done drops, so a late sample never sees the old value
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      adc_done <= 1'h0;
      adc_data <= 10'h2AA;
      ch <= 4'h0;
      wait_cnt <= 4'h0;
      hold_cnt <= 3'h0;
    end else if (adc_start === 1'h1) begin
      ch <= adc_channel;
      wait_cnt <= slow ? 4'h6 : 4'h2;
    end else if (wait_cnt != 4'h0) begin
      wait_cnt <= wait_cnt - 4'h1;
      if (wait_cnt == 4'h1) begin
        adc_done <= 1'h1;
        adc_data <= (ch == 4'h9) ? (hot ? 10'h3FF : 10'h010) : {ch, 6'h15};
        hold_cnt <= 3'h4;
      end
    end else if (hold_cnt != 3'h0) begin
      hold_cnt <= hold_cnt - 3'h1;
      if (hold_cnt == 3'h1) begin
        adc_done <= 1'h0;
        adc_data <= ~adc_data;
      end
    end
  end
endmodule // lds_conv_model
`default_nettype wire

// ### testbench/led_driver_status_and_timing_tb.sv
// self-checking bench for the LED driver control slice
// assumes lds_defines.svh on the include path and the converter model beside it
`timescale 1ns/1ns
`default_nettype none
`include "lds_defines.svh"
module led_driver_status_and_timing_tb;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic [7:0] address = 8'h00;
  logic read = 1'h0;
  logic write = 1'h0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic [9:1] status_cond = 9'h000;
  logic duty_above_half = 1'h0;
  logic led_switching_clock;
  logic [9:0] slope_mv_per_us;
  logic [3:0] adc_channel;
  logic adc_start;
  logic adc_done;
  logic [9:0] adc_data;
  logic irq_o;
  logic irq_oe;
  logic hot = 1'h1;
  logic slow = 1'h0;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  int starts = 0;
  int s;
  logic [5:0] codes [7] = '{6'h00, 6'h0A, 6'h0B, 6'h12, 6'h19, 6'h1A, 6'h1B};
  int divs [7] = '{8, 28, 32, 64, 150, 180, 180};
  int lo_tab [4] = '{100, 200, 300, 400};
  int hi_tab [4] = '{300, 400, 600, 900};

  lds_top #(.MEAS_PERIOD_CYC(200)) u_lds_top (.clk(clk), .rstn(rstn), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(4'hF),
    .readdata(readdata), .waitrequest(waitrequest), .status_cond(status_cond),
    .duty_above_half(duty_above_half), .led_switching_clock(led_switching_clock),
    .slope_mv_per_us(slope_mv_per_us), .adc_channel(adc_channel), .adc_start(adc_start),
    .adc_done(adc_done), .adc_data(adc_data), .interrupt_out_n_o(irq_o),
    .interrupt_out_n_oe(irq_oe));
  lds_conv_model u_lds_conv_model (.clk(clk), .rstn(rstn), .adc_start(adc_start),
    .adc_channel(adc_channel), .hot(hot), .slow(slow), .adc_done(adc_done),
    .adc_data(adc_data));

  // ==========================================================================
  // clock, timeout and report
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end
  task stop_test();
    $display("mismatches %0d, comparisons %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // channel order seen on every start
  always @(posedge clk) begin
    if (adc_start === 1'h1) begin
      chk({28'h0, adc_channel}, 32'(starts % 10));
      starts++;
    end
  end

  // ==========================================================================
  // bus access: request held until waitrequest is sampled low
  task bus(input logic wr_n, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    read <= ~wr_n;
    write <= wr_n;
    address <= a;
    writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'h0 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      stop_test();
    end
    q = readdata;
    read <= 1'h0;
    write <= 1'h0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'h0, a, 32'h0, q);
    chk(q, exp);
  endtask
  task period_chk(input int exp);
    time t0;
    repeat (2) @(posedge led_switching_clock);
    t0 = $time;
    @(posedge led_switching_clock);
    chk(32'(($time - t0) / 50), 32'(exp));
  endtask
  task wait_starts(input int k);
    int n;
    n = 0;
    while (starts < k && n < 1000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 1000) begin
      error_cnt++;
      stop_test();
    end
  endtask

  // ==========================================================================
  // tests
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'h1;
    rd_chk(`LDS_OFS_FREQ, 32'h4);
    period_chk(16);
    rd_chk(`LDS_OFS_SLOPE, 32'h0);
    chk({22'h0, slope_mv_per_us}, 32'(100));
    duty_above_half <= 1'h1;
    repeat (6) @(posedge clk);
    chk({22'h0, slope_mv_per_us}, 32'(300));
    foreach (lo_tab[i]) begin
      wr(`LDS_OFS_SLOPE, 32'(((3 - i) << 2) | i));
      duty_above_half <= 1'h0;
      repeat (6) @(posedge clk);
      chk({22'h0, slope_mv_per_us}, 32'(lo_tab[i]));
      duty_above_half <= 1'h1;
      repeat (6) @(posedge clk);
      chk({22'h0, slope_mv_per_us}, 32'(hi_tab[3 - i]));
    end
    wr(`LDS_OFS_SLOPE, 32'h0);
    duty_above_half <= 1'h0;
    repeat (6) @(posedge clk);
    chk({22'h0, slope_mv_per_us}, 32'(100));
    duty_above_half <= 1'h1;
    repeat (6) @(posedge clk);
    chk({22'h0, slope_mv_per_us}, 32'(300));
    foreach (codes[i]) begin
      wr(`LDS_OFS_FREQ, {26'h0, codes[i]});
      period_chk(divs[i]);
    end
    foreach (divs[i]) begin
      rd_chk(`LDS_OFS_RISE1 + 8'(i % 2) * 8'h0C, 32'h0);
    end
    // live, rise and fall on a first-register bit
    status_cond[3] <= 1'h1;
    repeat (6) @(posedge clk);
    rd_chk(`LDS_OFS_STATUS_LIVE_FIRST, 32'h08);
    rd_chk(`LDS_OFS_RISE1, 32'h08);
    rd_chk(`LDS_OFS_RISE1, 32'h00);
    status_cond[3] <= 1'h0;
    repeat (6) @(posedge clk);
    rd_chk(`LDS_OFS_STATUS_LIVE_FIRST, 32'h00);
    rd_chk(`LDS_OFS_FALL1, 32'h08);
    rd_chk(`LDS_OFS_FALL1, 32'h00);
    wr(`LDS_OFS_STATUS_LIVE_FIRST, 32'hFF);
    rd_chk(`LDS_OFS_STATUS_LIVE_FIRST, 32'h00);
    rd_chk(8'h30, 32'h0);
    // second register bit with the interrupt path
    status_cond[9] <= 1'h1;
    repeat (6) @(posedge clk);
    chk({31'h0, irq_oe}, 32'h0);
    wr(`LDS_OFS_RMASK, 32'h200);
    repeat (2) @(posedge clk);
    chk({31'h0, irq_oe}, 32'h1);
    chk({31'h0, irq_o}, 32'h0);
    rd_chk(`LDS_OFS_STAT2, 32'h2);
    rd_chk(`LDS_OFS_RISE2, 32'h2);
    repeat (2) @(posedge clk);
    chk({31'h0, irq_oe}, 32'h0);
    status_cond[9] <= 1'h0;
    // metrology sweeps
    repeat (300) @(posedge clk);
    chk(32'(starts), 32'h0);
    wr(`LDS_OFS_CTRL, 32'h1);
    wait_starts(10);
    repeat (40) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      rd_chk(`LDS_OFS_RES0 + 8'(4 * i), {16'h0, 4'(i), 6'h15, 6'h00});
    end
    rd_chk(`LDS_OFS_STATUS_LIVE_FIRST, 32'h01);
    chk(32'(starts), 32'(10));
    hot <= 1'h0;
    slow <= 1'h1;
    wait_starts(20);
    repeat (30) @(posedge clk);
    chk(32'(starts), 32'(20));
    rd_chk(`LDS_OFS_STATUS_LIVE_FIRST, 32'h00);
    wr(`LDS_OFS_CTRL, 32'h0);
    repeat (40) @(posedge clk);
    s = starts;
    repeat (400) @(posedge clk);
    chk(32'(starts), 32'(s));
    stop_test();
  end
endmodule // led_driver_status_and_timing_tb
`default_nettype wire
